// ---- design/eaw_pkg.sv ----
// Purpose: Shared constants and types for the area wait-timing controller
// Assumes: APB register window, 32-bit data, byte addresses
// Notes:   Hold code 11 behaves as code 10 (longest documented hold)
`default_nettype none
package eaw_pkg;
    // Register map
    localparam logic [7:0]  CFG_OFF   = 8'h00;
    localparam logic [7:0]  STAT_OFF  = 8'h04;
    // Configuration field positions
    localparam int          AW_LSB    = 7;
    localparam int          MASK_BIT  = 6;
    localparam int          HOLD_LSB  = 0;
    localparam int          CFG_W     = 11;
    // Reset value: wait code 1010, mask 0, hold 00
    localparam logic [10:0] CFG_RST   = 11'h500;
    // Writable bits; bits 5..2 stay zero
    localparam logic [10:0] CFG_WMASK = 11'h7c3;
    localparam int          CNT_W     = 5;
    // Wait cycles per access-wait code; reserved codes take the longest
    localparam logic [4:0]  WAIT_TBL [16] = '{
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
        5'h0a, 5'h0c, 5'h0e, 5'h12, 5'h18, 5'h18, 5'h18, 5'h18};
    // Whole cycles of hold after the first half cycle, per hold code
    localparam logic [1:0]  HOLD_TBL [4] = '{2'h0, 2'h1, 2'h2, 2'h2};

    typedef enum logic [1:0] {
        EAW_IDLE   = 2'b00,
        EAW_STROBE = 2'b01,
        EAW_HOLD   = 2'b10
    } eaw_state_e;
endpackage
`default_nettype wire

// ---- design/eaw_sync2.sv ----
// Purpose: Two-flop synchroniser for the external wait pin
// Assumes: Pin is asynchronous to pclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module eaw_sync2 (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output var  logic dout
);
    logic meta;
    logic next_meta;
    logic next_dout;

    always_comb begin
        next_meta = din;
        next_dout = meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule // eaw_sync2
`default_nettype wire

// ---- design/eaw_wait_cnt.sv ----
// Purpose: Down-counter of programmed access wait cycles
// Assumes: Load and decrement never come together
// Notes:   Cycle count comes from the shared wait table
`timescale 1ns/10ps
`default_nettype none
module eaw_wait_cnt
    import eaw_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       load,
    input  wire logic [3:0] code,
    input  wire logic       dec,
    output var  logic       zero
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (load) begin
            next_cnt = WAIT_TBL[code];
        end else if (dec && cnt != '0) begin
            next_cnt = cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign zero = (cnt == '0);
endmodule // eaw_wait_cnt
`default_nettype wire

// ---- design/eaw_area_ctrl.sv ----
// Purpose: APB-configured wait and hold timing for one chip-select area
// Assumes: One access request at a time, held off while busy is high
// Notes:   Select and address negate on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Wait code 0000 adds no read wait cycle, 0001 adds one.
// - Codes 0101 and 0110 add five and six waits; 0111 adds eight.
// - Codes 1000 to 1100 add 10, 12, 14, 18 and 24 waits.
// - Mask bit clear honours the external wait pin; set ignores it.
// - The mask applies even with zero programmed waits.
// - Mask bit 6 resets to zero and is read-write.
// - Bits 5 to 2 always read back as zero.
// - Hold code 00, 01, 10 gives 0.5, 1.5, 2.5 cycles hold.
// - Hold bit 1 resets to zero and is read-write.
module eaw_area_ctrl
    import eaw_pkg::*;
#(
    parameter int AW = 16,
    parameter int DW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    input  wire logic          req,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    input  wire logic [1:0]    req_be,
    output var  logic          busy,
    output var  logic          ack,
    output var  logic [DW-1:0] rdata,
    output var  logic [AW-1:0] ext_addr,
    output var  logic [DW-1:0] data_out,
    input  wire logic [DW-1:0] data_in,
    output var  logic          data_oe_n,
    output var  logic          rd_n,
    output var  logic          wr_n,
    output var  logic [1:0]    byte_strobe_n,
    output var  logic          area_select_n,
    input  wire logic          ext_wait_n
);
    // Configuration and APB state
    logic [CFG_W-1:0] cfg;
    logic [CFG_W-1:0] next_cfg;
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    logic             setup;
    logic             wr_hit;
    logic             hit_cfg;
    logic             hit_stat;
    logic             wait_seen;
    logic             next_wait_seen;

    // Access sequencer state
    eaw_state_e       state;
    eaw_state_e       next_state;
    logic [1:0]       hold_cnt;
    logic [1:0]       next_hold_cnt;
    logic             cs_on;
    logic             next_cs_on;
    logic [AW-1:0]    addr_q;
    logic [AW-1:0]    next_addr_q;
    logic             write_q;
    logic             next_write_q;
    logic [3:0]       lat_code;
    logic [3:0]       next_lat_code;
    logic             lat_mask;
    logic             next_lat_mask;
    logic [1:0]       lat_hold;
    logic [1:0]       next_lat_hold;
    logic             next_busy;
    logic             next_ack;
    logic [DW-1:0]    next_rdata;
    logic [DW-1:0]    next_data_out;
    logic             next_data_oe_n;
    logic             next_rd_n;
    logic             next_wr_n;
    logic [1:0]       next_byte_strobe_n;
    logic             start;
    logic             cnt_zero;
    logic             cnt_dec;
    logic             wait_sync;
    logic             ext_hold;
    logic             finish;

    // Pin is active low; synchronised level is active high
    eaw_sync2 u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (!ext_wait_n),
        .dout    (wait_sync)
    );

    // Writes carry no programmed waits
    eaw_wait_cnt u_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (start),
        .code    (req_write ? 4'h0 : cfg[AW_LSB +: 4]),
        .dec     (cnt_dec),
        .zero    (cnt_zero)
    );

    // APB slave: one wait-free access phase, answer prepared at setup
    assign setup    = psel && !penable && !pready;
    assign wr_hit   = psel && penable && pready && pwrite;
    assign hit_cfg  = (paddr == CFG_OFF);
    assign hit_stat = (paddr == STAT_OFF);

    always_comb begin
        next_cfg       = cfg;
        next_prdata    = prdata;
        next_pready    = 1'b0;
        next_pslverr   = 1'b0;
        next_wait_seen = wait_seen || (wait_sync && state == EAW_STROBE);
        if (setup) begin
            next_pready  = 1'b1;
            next_pslverr = !(hit_cfg || hit_stat);
            next_prdata  = 32'h0;
            if (hit_cfg) begin
                next_prdata[CFG_W-1:0] = cfg & CFG_WMASK;
            end else if (hit_stat) begin
                next_prdata[7:0] = {lat_code, wait_seen, write_q,
                                    cs_on, busy};
            end
        end
        if (wr_hit && hit_cfg) begin
            next_cfg = pwdata[CFG_W-1:0] & CFG_WMASK;
        end
        // A fresh wait event wins over the clear
        if (wr_hit && hit_stat && pwdata[2]) begin
            next_wait_seen = wait_sync && state == EAW_STROBE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg       <= CFG_RST;
            prdata    <= 32'h0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            wait_seen <= 1'b0;
        end else begin
            cfg       <= next_cfg;
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            wait_seen <= next_wait_seen;
        end
    end

    // Sequencer; settings are latched at start so a rewrite mid-access
    // cannot tear the running timing
    assign start    = (state == EAW_IDLE) && req;
    assign ext_hold = wait_sync && !lat_mask;
    assign cnt_dec  = (state == EAW_STROBE);
    assign finish   = (state == EAW_STROBE) && cnt_zero && !ext_hold;

    always_comb begin
        next_state         = state;
        next_hold_cnt      = hold_cnt;
        next_cs_on         = cs_on;
        next_addr_q        = addr_q;
        next_write_q       = write_q;
        next_lat_code      = lat_code;
        next_lat_mask      = lat_mask;
        next_lat_hold      = lat_hold;
        next_busy          = busy;
        next_ack           = 1'b0;
        next_rdata         = rdata;
        next_data_out      = data_out;
        next_data_oe_n     = data_oe_n;
        next_rd_n          = rd_n;
        next_wr_n          = wr_n;
        next_byte_strobe_n = byte_strobe_n;
        unique case (state)
            EAW_IDLE: begin
                if (req) begin
                    next_state         = EAW_STROBE;
                    next_busy          = 1'b1;
                    next_cs_on         = 1'b1;
                    next_addr_q        = req_addr;
                    next_write_q       = req_write;
                    next_lat_code      = cfg[AW_LSB +: 4];
                    next_lat_mask      = cfg[MASK_BIT];
                    next_lat_hold      = cfg[HOLD_LSB +: 2];
                    next_rd_n          = req_write;
                    next_wr_n          = !req_write;
                    next_byte_strobe_n = req_write ? ~req_be : 2'b00;
                    next_data_out      = req_wdata;
                    next_data_oe_n     = !req_write;
                end
            end
            EAW_STROBE: begin
                // Programmed waits run down first, then the pin may extend
                if (finish) begin
                    next_rd_n          = 1'b1;
                    next_wr_n          = 1'b1;
                    next_byte_strobe_n = 2'b11;
                    next_ack           = 1'b1;
                    if (!write_q) begin
                        next_rdata = data_in;
                    end
                    if (HOLD_TBL[lat_hold] == 2'h0) begin
                        next_cs_on     = 1'b0;
                        next_busy      = 1'b0;
                        next_data_oe_n = 1'b1;
                        next_state     = EAW_IDLE;
                    end else begin
                        next_hold_cnt  = HOLD_TBL[lat_hold] - 2'h1;
                        next_state     = EAW_HOLD;
                    end
                end
            end
            EAW_HOLD: begin
                if (hold_cnt == 2'h0) begin
                    next_cs_on     = 1'b0;
                    next_busy      = 1'b0;
                    next_data_oe_n = 1'b1;
                    next_state     = EAW_IDLE;
                end else begin
                    next_hold_cnt = hold_cnt - 2'h1;
                end
            end
            default: begin
                next_state = EAW_IDLE;
                next_busy  = 1'b0;
                next_cs_on = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= EAW_IDLE;
            hold_cnt      <= 2'h0;
            cs_on         <= 1'b0;
            addr_q        <= '0;
            write_q       <= 1'b0;
            lat_code      <= 4'h0;
            lat_mask      <= 1'b0;
            lat_hold      <= 2'h0;
            busy          <= 1'b0;
            ack           <= 1'b0;
            rdata         <= '0;
            data_out      <= '0;
            data_oe_n     <= 1'b1;
            rd_n          <= 1'b1;
            wr_n          <= 1'b1;
            byte_strobe_n <= 2'b11;
        end else begin
            state         <= next_state;
            hold_cnt      <= next_hold_cnt;
            cs_on         <= next_cs_on;
            addr_q        <= next_addr_q;
            write_q       <= next_write_q;
            lat_code      <= next_lat_code;
            lat_mask      <= next_lat_mask;
            lat_hold      <= next_lat_hold;
            busy          <= next_busy;
            ack           <= next_ack;
            rdata         <= next_rdata;
            data_out      <= next_data_out;
            data_oe_n     <= next_data_oe_n;
            rd_n          <= next_rd_n;
            wr_n          <= next_wr_n;
            byte_strobe_n <= next_byte_strobe_n;
        end
    end

    // Half-cycle offset: select and address follow on the falling edge
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            area_select_n <= 1'b1;
            ext_addr      <= '0;
        end else begin
            area_select_n <= !cs_on;
            ext_addr      <= cs_on ? addr_q : '0;
        end
    end

    // Checks
    logic [5:0] rd_len;
    logic       first;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_len <= 6'h0;
            first  <= 1'b1;
        end else begin
            rd_len <= rd_n ? 6'h0 : rd_len + 6'h1;
            first  <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_rd_start;
        $fell(rd_n) && lat_mask;
    endsequence

    a_wait_zero_code: assert property (
        s_rd_start and (lat_code == 4'h0) |=> rd_n)
        else $error("wait code 0 read strobe not one cycle");
    a_wait_one_code: assert property (
        s_rd_start and (lat_code == 4'h1) |=> !rd_n ##1 rd_n)
        else $error("wait code 1 read strobe not two cycles");
    a_wait_six_code: assert property (
        s_rd_start and (lat_code == 4'h6) |=> !rd_n[*6] ##1 rd_n)
        else $error("wait code 6 read strobe not seven cycles");
    a_wait_eight_code: assert property (
        s_rd_start and (lat_code == 4'h7) |=> !rd_n[*8] ##1 rd_n)
        else $error("wait code 7 read strobe not nine cycles");
    a_wait_upper_codes: assert property (
        $rose(rd_n) && lat_mask && lat_code == 4'hc |-> rd_len == 6'd25)
        else $error("wait code c read strobe length wrong");
    a_mask_ignores_pin: assert property (
        state == EAW_STROBE && cnt_zero && lat_mask |=> rd_n && wr_n)
        else $error("masked wait pin extended access");
    a_pin_extends_zero: assert property (
        state == EAW_STROBE && cnt_zero && wait_sync && !lat_mask
        |=> state == EAW_STROBE && ack == 1'b0)
        else $error("unmasked wait pin not honoured");
    a_reserved_read_zero: assert property (
        psel && penable && pready && hit_cfg |-> prdata[5:2] == 4'h0)
        else $error("reserved bits read non-zero");
    a_cfg_reset_value: assert property (
        first |-> !cfg[MASK_BIT] && !cfg[1] && !cfg[AW_LSB])
        else $error("configuration reset value wrong");
    a_hold_half_cycle: assert property (
        $rose(ack) && lat_hold == 2'b00 |-> area_select_n)
        else $error("hold 00 select not released after half cycle");
    a_hold_one_half: assert property (
        $rose(ack) && lat_hold == 2'b01 |-> !area_select_n ##1 area_select_n)
        else $error("hold 01 select timing wrong");
endmodule // eaw_area_ctrl
`default_nettype wire

// ---- testbench/eaw_ext_mem.sv ----
// Purpose: External memory model on the area's asynchronous bus
// Assumes: Read data depends on the address only
// Notes:   A pulse on arm holds the wait pin low for WAIT_LEN cycles
`timescale 1ns/10ps
`default_nettype none
module eaw_ext_mem #(
    parameter int WAIT_LEN = 12
) (
    input  wire logic        pclk,
    input  wire logic        arm,
    input  wire logic [15:0] ext_addr,
    input  wire logic [15:0] data_out,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [1:0]  byte_strobe_n,
    input  wire logic        area_select_n,
    output var  logic [15:0] data_in,
    output var  logic        ext_wait_n,
    output var  logic [15:0] wr_data,
    output var  logic [1:0]  wr_be_n
);
    logic [7:0]  cnt = 8'h00;
    logic [15:0] last = 16'h0000;
    // A released bus shows the inverse of its last value, never a held copy
    always_comb data_in = (!area_select_n && !rd_n) ? (ext_addr ^ 16'ha5c3) : ~last;
    always_comb ext_wait_n = (cnt == 8'h00);
    always_ff @(posedge pclk) begin
        if (!area_select_n && !rd_n) last <= ext_addr ^ 16'ha5c3;
        if (arm) cnt <= 8'(WAIT_LEN);
        else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
    always_ff @(negedge pclk) begin
        if (!wr_n) begin
            wr_data <= data_out;
            wr_be_n <= byte_strobe_n;
        end
    end
endmodule // eaw_ext_mem
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the area wait-timing controller
// Assumes: APB master in the bench, memory model on the far side
// Notes:   Strobe length is counted just after each rising edge
`timescale 1ns/10ps
`default_nettype none
module tb;
    import eaw_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, req = 1'b0, req_write = 1'b0, arm = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, serr, busy, ack, data_oe_n, rd_n, wr_n;
    logic        area_select_n, ext_wait_n;
    logic [15:0] req_addr = 16'h0, req_wdata = 16'h0, rdata, ext_addr, data_out;
    logic [15:0] data_in, wr_data;
    logic [1:0]  req_be = 2'b00, byte_strobe_n, wr_be_n;
    int          errors = 0, n_compared = 0, cyc = 0, n, m;
    realtime     t0, t1;
    int          wtbl [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};

    eaw_area_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .req, .req_write, .req_addr, .req_wdata, .req_be,
        .busy, .ack, .rdata, .ext_addr, .data_out, .data_in, .data_oe_n, .rd_n, .wr_n,
        .byte_strobe_n, .area_select_n, .ext_wait_n);
    eaw_ext_mem mem (.pclk, .arm, .ext_addr, .data_out, .rd_n, .wr_n, .byte_strobe_n,
        .area_select_n, .data_in, .ext_wait_n, .wr_data, .wr_be_n);

    always #10 pclk = ~pclk;

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // A hung handshake ends the run through the same report
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Taken at the rising edge, before that edge's own updates land
        do @(posedge pclk); while (!(pready === 1'b1 && psel && penable));
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [3:0] code, input logic m, input logic [1:0] h);
        apb(1'b1, CFG_OFF, {21'h0, code, m, 4'h0, h});
    endtask

    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge pclk);
        while (busy !== 1'b0) @(negedge pclk);
        @(posedge pclk);
        req <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        req_be <= 2'b01;
        @(posedge pclk);
        req <= 1'b0;
        n = 0;
        m = 0;
        repeat (80) begin
            #1;
            if (rd_n === 1'b0 || wr_n === 1'b0) n++;
            if (wr_n === 1'b0 && data_oe_n === 1'b0) m++;
            if (ack === 1'b1) break;
            @(posedge pclk);
        end
        if (!w) chk(32'(rdata), 32'(a ^ 16'ha5c3));
    endtask

    task automatic t_regs();
        apb(1'b0, CFG_OFF, 32'h0);
        chk(r, 32'h500);
        // Code 1011, mask set, hold 10: bits 7, 6 and 1 all go high
        apb(1'b1, CFG_OFF, 32'h5c2);
        apb(1'b0, CFG_OFF, 32'h0);
        chk(r, 32'h5c2);
        // Software keeps bits 5..2 at zero, so only the read side is judged
        apb(1'b1, CFG_OFF, 32'h600);
        apb(1'b0, CFG_OFF, 32'h0);
        chk(r, 32'h600);
        apb(1'b0, 8'h08, 32'h0);
        chk({r[30:0], serr}, 32'h1);
        $display("registers done");
    endtask

    task automatic t_codes();
        for (int i = 0; i < 13; i++) begin
            cfg(4'(i), 1'b1, 2'b00);
            acc(1'b0, 16'(i * 16'h0111), 16'h0);
            chk(32'(n), 32'(1 + wtbl[i]));
        end
        $display("wait codes done");
    endtask

    task automatic armed(input logic w, input logic [3:0] code, input logic m);
        cfg(code, m, 2'b00);
        @(posedge pclk);
        arm <= 1'b1;
        @(posedge pclk);
        arm <= 1'b0;
        acc(w, 16'h1234, 16'h3c5a);
    endtask

    task automatic t_mask();
        armed(1'b0, 4'h0, 1'b1);
        chk(32'(n), 32'h1);
        armed(1'b0, 4'h0, 1'b0);
        chk(32'(n > 1), 32'h1);
        armed(1'b0, 4'h2, 1'b0);
        chk(32'(n > 3), 32'h1);
        armed(1'b1, 4'h0, 1'b0);
        chk(32'(n > 1), 32'h1);
        chk({wr_be_n, wr_data}, {14'h0, 2'b10, 16'h3c5a});
        chk(32'(m), 32'(n));
        // Status: wait seen, last was write, idle
        apb(1'b0, STAT_OFF, 32'h0);
        chk(r, 32'h0c);
        apb(1'b1, STAT_OFF, 32'h4);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(r, 32'h04);
        $display("external wait done");
    endtask

    task automatic t_hold();
        for (int h = 0; h < 3; h++) begin
            cfg(4'h0, 1'b1, 2'(h));
            fork
                acc(1'b0, 16'h0042, 16'h0);
                begin
                    @(posedge rd_n) t0 = $realtime;
                    @(posedge area_select_n) t1 = $realtime;
                end
            join
            chk(32'(int'(t1 - t0)), 32'(10 + 20 * h));
        end
        $display("hold delay done");
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_codes();
        t_mask();
        t_hold();
        close_out();
    end
endmodule // tb
`default_nettype wire
